// [src/agl_defs.vh]
// Purpose: Constants for the gain, LED current and power register bank
// Assumes: 24-bit registers at word addresses 20h to 23h
// Notes: Included by agl_regs.v and agl_gain_decode.v
// Behaviour
// - All four registers 20h to 23h reset to zero.
// - Bit 15 of 20h chooses one shared gain set or two separate sets.
// - With separate gains, 20h bits 5-3 set the second feedback capacitor.
// - With separate gains, 20h bits 2-0 set the second feedback resistor.
// - Write-only bit 8 of 21h swaps conversion-ready for programmable pulse.
// - Programmable pulse starts and ends at its start and end counts.
// - 21h bits 5-3 set both capacitors, or only the first when separate.
// - 21h bits 2-0 set both resistors, or only the first when separate.
// - Resistor codes 0-7: 500k,250k,100k,50k,25k,10k,1M,2M ohms.
// - Capacitor codes 0-7: 5,2.5,10,7.5,20,17.5,25,22.5 pF.
// - 22h holds third LED 17-12, second 11-6, first 5-0.
// - LED code is linear, 0.8 mA a step, code 0 gives no current.
// - Bit 17 of 23h doubles the LED current range to 100 mA.
// - Bit 9 of 23h picks internal 4-MHz oscillator over external clock.
// - 23h bit 1 powers down receiver, bit 0 the whole front end.
// - 23h bits 20,14,4,3 power down blocks in dynamic power-down.
`ifndef AGL_DEFS_VH
`define AGL_DEFS_VH

////////////////////////////////////////////////////////////////////////////
// Register addresses and width
`define AGL_ADDR_W 8
`define AGL_DATA_W 24
`define AGL_ADDR_SECOND_GAIN 8'h20
`define AGL_ADDR_PRIMARY_GAIN 8'h21
`define AGL_ADDR_LED_CURRENT 8'h22
`define AGL_ADDR_POWER_CLOCK 8'h23
`define AGL_RESET_VALUE 24'h000000

////////////////////////////////////////////////////////////////////////////
// Readable bit masks per register (write-only and reserved read as zero)
`define AGL_MASK_SECOND_GAIN 24'h00803f
`define AGL_MASK_PRIMARY_GAIN 24'h00003f
`define AGL_MASK_LED_CURRENT 24'h03ffff
`define AGL_MASK_POWER_CLOCK 24'h12421b

////////////////////////////////////////////////////////////////////////////
// Field positions
`define AGL_SEP_GAIN_BIT 15
`define AGL_CAP_MSB 5
`define AGL_CAP_LSB 3
`define AGL_RES_MSB 2
`define AGL_RES_LSB 0
`define AGL_PULSE_SEL_BIT 8
`define AGL_LED3_MSB 17
`define AGL_LED3_LSB 12
`define AGL_LED2_MSB 11
`define AGL_LED2_LSB 6
`define AGL_LED1_MSB 5
`define AGL_LED1_LSB 0
`define AGL_DYN_TX_BIT 20
`define AGL_DOUBLE_RANGE_BIT 17
`define AGL_DYN_ADC_BIT 14
`define AGL_INT_CLK_BIT 9
`define AGL_DYN_TIA_BIT 4
`define AGL_DYN_ADC_REST_BIT 3
`define AGL_RX_PD_BIT 1
`define AGL_FULL_PD_BIT 0

////////////////////////////////////////////////////////////////////////////
// Analog setting scales
`define AGL_OHMS_W 21
`define AGL_CAP_W 8
`define AGL_LED_UA_W 17
`define AGL_LED_STEP_UA 17'd800
`define AGL_COUNT_W 16

`endif

// [src/agl_gain_decode.v]
// Purpose: Decode one resistor code and one capacitor code to values
// Assumes: Codes are 3 bits each; outputs are combinational
// Notes: Capacitance is given in tenths of a picofarad
`include "agl_defs.vh"

module agl_gain_decode (
  input wire [2:0] res_code_in,
  input wire [2:0] cap_code_in,
  output wire [`AGL_OHMS_W-1:0] ohms_out,
  output wire [`AGL_CAP_W-1:0] cap_tenth_pf_out
);

  ////////////////////////////////////////////////////////////////////////
  // Resistor table, note the non-monotonic order of the top two codes
  function [`AGL_OHMS_W-1:0] res_ohms;
    input [2:0] code;
    begin
      case (code)
        3'h0: res_ohms = 21'd500000;
        3'h1: res_ohms = 21'd250000;
        3'h2: res_ohms = 21'd100000;
        3'h3: res_ohms = 21'd50000;
        3'h4: res_ohms = 21'd25000;
        3'h5: res_ohms = 21'd10000;
        3'h6: res_ohms = 21'd1000000;
        default: res_ohms = 21'd2000000;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Capacitor table in 0.1 pF units so half steps stay exact
  function [`AGL_CAP_W-1:0] cap_tenths;
    input [2:0] code;
    begin
      case (code)
        3'h0: cap_tenths = 8'd50;
        3'h1: cap_tenths = 8'd25;
        3'h2: cap_tenths = 8'd100;
        3'h3: cap_tenths = 8'd75;
        3'h4: cap_tenths = 8'd200;
        3'h5: cap_tenths = 8'd175;
        3'h6: cap_tenths = 8'd250;
        default: cap_tenths = 8'd225;
      endcase
    end
  endfunction

  // Pure lookup, registered by the caller
  assign ohms_out = res_ohms(res_code_in);
  assign cap_tenth_pf_out = cap_tenths(cap_code_in);

endmodule // agl_gain_decode

// [src/agl_regs.v]
// Purpose: Gain, LED current and power configuration registers 20h-23h
// Assumes: Register port and timing-engine inputs run on CLOCK_IN
// Notes: Every output is a flip-flop; settings lag a write by one cycle
`include "agl_defs.vh"

module agl_regs (
  input wire CLOCK_IN,
  input wire SYS_RST_IN,
  input wire REG_WR_EN_IN,
  input wire REG_RD_EN_IN,
  input wire [`AGL_ADDR_W-1:0] REG_ADDR_IN,
  input wire [`AGL_DATA_W-1:0] REG_WDATA_IN,
  input wire ADC_READY_IN,
  input wire [`AGL_COUNT_W-1:0] TIMING_COUNT_IN,
  input wire [`AGL_COUNT_W-1:0] PROG_PULSE_START_COUNT_IN,
  input wire [`AGL_COUNT_W-1:0] PROG_PULSE_END_COUNT_IN,
  output reg [`AGL_DATA_W-1:0] REG_RDATA_OUT,
  output reg REG_RVALID_OUT,
  output reg READY_PIN_OUT,
  output reg SEPARATE_GAIN_ENABLE_OUT,
  output reg [2:0] FIRST_RES_CODE_OUT,
  output reg [2:0] SECOND_RES_CODE_OUT,
  output reg [2:0] FIRST_CAP_CODE_OUT,
  output reg [2:0] SECOND_CAP_CODE_OUT,
  output reg [`AGL_OHMS_W-1:0] FIRST_RES_OHMS_OUT,
  output reg [`AGL_OHMS_W-1:0] SECOND_RES_OHMS_OUT,
  output reg [`AGL_CAP_W-1:0] FIRST_CAP_TENTH_PF_OUT,
  output reg [`AGL_CAP_W-1:0] SECOND_CAP_TENTH_PF_OUT,
  output reg [`AGL_LED_UA_W-1:0] FIRST_LED_UA_OUT,
  output reg [`AGL_LED_UA_W-1:0] SECOND_LED_UA_OUT,
  output reg [`AGL_LED_UA_W-1:0] THIRD_LED_UA_OUT,
  output reg DOUBLE_CURRENT_RANGE_OUT,
  output reg INTERNAL_CLOCK_SELECT_OUT,
  output reg RECEIVER_POWERDOWN_OUT,
  output reg FULL_POWERDOWN_OUT,
  output reg DYN_PD_TRANSMITTER_OUT,
  output reg DYN_PD_CONVERTER_OUT,
  output reg DYN_PD_AMPLIFIER_OUT,
  output reg DYN_PD_CONVERTER_REST_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // Storage; full 24-bit words, unimplemented bits held at zero by the write masks
  reg [`AGL_DATA_W-1:0] second_gain_set_control_reg;
  reg [`AGL_DATA_W-1:0] primary_gain_and_ready_select_reg;
  reg [`AGL_DATA_W-1:0] led_current_codes_reg;
  reg [`AGL_DATA_W-1:0] power_and_clock_control_reg;
  reg programmable_pulse_select_reg;
  reg prog_pulse_reg;
  reg prog_pulse_next;

  wire separate_gain_enable;
  wire [2:0] feedback_res_code;
  wire [2:0] feedback_cap_code;
  wire [2:0] second_feedback_res_code;
  wire [2:0] second_feedback_cap_code;
  wire [2:0] first_res_sel;
  wire [2:0] second_res_sel;
  wire [2:0] first_cap_sel;
  wire [2:0] second_cap_sel;
  wire [5:0] first_led_current_code;
  wire [5:0] second_led_current_code;
  wire [5:0] third_led_current_code;
  wire double_current_range;
  wire [`AGL_OHMS_W-1:0] ohms_dec [0:1];
  wire [`AGL_CAP_W-1:0] cap_dec [0:1];
  wire [`AGL_DATA_W-1:0] rdata_next;

  ////////////////////////////////////////////////////////////////////////
  // Readback mask per address; unmapped addresses give zero
  function [`AGL_DATA_W-1:0] read_mask;
    input [`AGL_ADDR_W-1:0] addr;
    begin
      case (addr)
        `AGL_ADDR_SECOND_GAIN: read_mask = `AGL_MASK_SECOND_GAIN;
        `AGL_ADDR_PRIMARY_GAIN: read_mask = `AGL_MASK_PRIMARY_GAIN;
        `AGL_ADDR_LED_CURRENT: read_mask = `AGL_MASK_LED_CURRENT;
        `AGL_ADDR_POWER_CLOCK: read_mask = `AGL_MASK_POWER_CLOCK;
        default: read_mask = 24'h000000;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // LED code to microamps; doubling range doubles every step
  function [`AGL_LED_UA_W-1:0] led_ua;
    input [5:0] code;
    input dbl;
    reg [`AGL_LED_UA_W-1:0] base;
    begin
      base = `AGL_LED_STEP_UA * {11'h000, code};
      led_ua = dbl ? {base[`AGL_LED_UA_W-2:0], 1'b0} : base;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are masked off so stray ones from
  // software that ignores the write-zero convention cannot leak out
  always @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      second_gain_set_control_reg <= `AGL_RESET_VALUE;
      primary_gain_and_ready_select_reg <= `AGL_RESET_VALUE;
      led_current_codes_reg <= `AGL_RESET_VALUE;
      power_and_clock_control_reg <= `AGL_RESET_VALUE;
      programmable_pulse_select_reg <= 1'b0;
    end else if (REG_WR_EN_IN) begin
      case (REG_ADDR_IN)
        `AGL_ADDR_SECOND_GAIN: begin
          second_gain_set_control_reg <=
            REG_WDATA_IN & `AGL_MASK_SECOND_GAIN;
        end
        `AGL_ADDR_PRIMARY_GAIN: begin
          primary_gain_and_ready_select_reg <=
            REG_WDATA_IN & `AGL_MASK_PRIMARY_GAIN;
          programmable_pulse_select_reg <=
            REG_WDATA_IN[`AGL_PULSE_SEL_BIT];
        end
        `AGL_ADDR_LED_CURRENT: begin
          led_current_codes_reg <= REG_WDATA_IN & `AGL_MASK_LED_CURRENT;
        end
        `AGL_ADDR_POWER_CLOCK: begin
          power_and_clock_control_reg <=
            REG_WDATA_IN & `AGL_MASK_POWER_CLOCK;
        end
        default: begin
          second_gain_set_control_reg <= second_gain_set_control_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field extraction
  assign separate_gain_enable =
    second_gain_set_control_reg[`AGL_SEP_GAIN_BIT];
  assign second_feedback_cap_code =
    second_gain_set_control_reg[`AGL_CAP_MSB:`AGL_CAP_LSB];
  assign second_feedback_res_code =
    second_gain_set_control_reg[`AGL_RES_MSB:`AGL_RES_LSB];
  assign feedback_cap_code =
    primary_gain_and_ready_select_reg[`AGL_CAP_MSB:`AGL_CAP_LSB];
  assign feedback_res_code =
    primary_gain_and_ready_select_reg[`AGL_RES_MSB:`AGL_RES_LSB];
  assign first_led_current_code =
    led_current_codes_reg[`AGL_LED1_MSB:`AGL_LED1_LSB];
  assign second_led_current_code =
    led_current_codes_reg[`AGL_LED2_MSB:`AGL_LED2_LSB];
  assign third_led_current_code =
    led_current_codes_reg[`AGL_LED3_MSB:`AGL_LED3_LSB];
  assign double_current_range =
    power_and_clock_control_reg[`AGL_DOUBLE_RANGE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Gain set selection: the primary fields feed both sets unless the
  // separate mode hands the second set to its own fields
  assign first_res_sel = feedback_res_code;
  assign first_cap_sel = feedback_cap_code;
  assign second_res_sel = separate_gain_enable ?
    second_feedback_res_code : feedback_res_code;
  assign second_cap_sel = separate_gain_enable ?
    second_feedback_cap_code : feedback_cap_code;

  ////////////////////////////////////////////////////////////////////////
  // One decoder per gain set
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_gain_dec
      agl_gain_decode u_dec (
        .res_code_in((g == 0) ? first_res_sel : second_res_sel),
        .cap_code_in((g == 0) ? first_cap_sel : second_cap_sel),
        .ohms_out(ohms_dec[g]),
        .cap_tenth_pf_out(cap_dec[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Programmable pulse: rises at the start count, falls at the end count;
  // if both match in one cycle the fall wins so the pin stays low
  always @* begin
    prog_pulse_next = prog_pulse_reg;
    if (TIMING_COUNT_IN == PROG_PULSE_START_COUNT_IN) begin
      prog_pulse_next = 1'b1;
    end
    if (TIMING_COUNT_IN == PROG_PULSE_END_COUNT_IN) begin
      prog_pulse_next = 1'b0;
    end
  end

  always @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      prog_pulse_reg <= 1'b0;
    end else begin
      prog_pulse_reg <= prog_pulse_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback; the pulse select bit is absent from the mask
  assign rdata_next = (REG_ADDR_IN == `AGL_ADDR_SECOND_GAIN) ?
      second_gain_set_control_reg :
    (REG_ADDR_IN == `AGL_ADDR_PRIMARY_GAIN) ?
      primary_gain_and_ready_select_reg :
    (REG_ADDR_IN == `AGL_ADDR_LED_CURRENT) ? led_current_codes_reg :
      power_and_clock_control_reg;

  // Read data is held until the next read so a slow host can sample it
  always @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      REG_RDATA_OUT <= `AGL_RESET_VALUE;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_EN_IN;
      if (REG_RD_EN_IN) begin
        REG_RDATA_OUT <= rdata_next & read_mask(REG_ADDR_IN);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ready pin: normal conversion-ready, or the timing-engine pulse
  always @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      READY_PIN_OUT <= 1'b0;
    end else begin
      READY_PIN_OUT <= programmable_pulse_select_reg ?
        prog_pulse_next : ADC_READY_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog settings, registered so the pins see no decode glitches
  always @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      SEPARATE_GAIN_ENABLE_OUT <= 1'b0;
      FIRST_RES_CODE_OUT <= 3'h0;
      SECOND_RES_CODE_OUT <= 3'h0;
      FIRST_CAP_CODE_OUT <= 3'h0;
      SECOND_CAP_CODE_OUT <= 3'h0;
      FIRST_RES_OHMS_OUT <= 21'd500000;
      SECOND_RES_OHMS_OUT <= 21'd500000;
      FIRST_CAP_TENTH_PF_OUT <= 8'd50;
      SECOND_CAP_TENTH_PF_OUT <= 8'd50;
      FIRST_LED_UA_OUT <= 17'h00000;
      SECOND_LED_UA_OUT <= 17'h00000;
      THIRD_LED_UA_OUT <= 17'h00000;
    end else begin
      SEPARATE_GAIN_ENABLE_OUT <= separate_gain_enable;
      FIRST_RES_CODE_OUT <= first_res_sel;
      SECOND_RES_CODE_OUT <= second_res_sel;
      FIRST_CAP_CODE_OUT <= first_cap_sel;
      SECOND_CAP_CODE_OUT <= second_cap_sel;
      FIRST_RES_OHMS_OUT <= ohms_dec[0];
      SECOND_RES_OHMS_OUT <= ohms_dec[1];
      FIRST_CAP_TENTH_PF_OUT <= cap_dec[0];
      SECOND_CAP_TENTH_PF_OUT <= cap_dec[1];
      FIRST_LED_UA_OUT <=
        led_ua(first_led_current_code, double_current_range);
      SECOND_LED_UA_OUT <=
        led_ua(second_led_current_code, double_current_range);
      THIRD_LED_UA_OUT <=
        led_ua(third_led_current_code, double_current_range);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power and clock controls
  always @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      DOUBLE_CURRENT_RANGE_OUT <= 1'b0;
      INTERNAL_CLOCK_SELECT_OUT <= 1'b0;
      RECEIVER_POWERDOWN_OUT <= 1'b0;
      FULL_POWERDOWN_OUT <= 1'b0;
      DYN_PD_TRANSMITTER_OUT <= 1'b0;
      DYN_PD_CONVERTER_OUT <= 1'b0;
      DYN_PD_AMPLIFIER_OUT <= 1'b0;
      DYN_PD_CONVERTER_REST_OUT <= 1'b0;
    end else begin
      DOUBLE_CURRENT_RANGE_OUT <= double_current_range;
      INTERNAL_CLOCK_SELECT_OUT <=
        power_and_clock_control_reg[`AGL_INT_CLK_BIT];
      RECEIVER_POWERDOWN_OUT <=
        power_and_clock_control_reg[`AGL_RX_PD_BIT];
      FULL_POWERDOWN_OUT <=
        power_and_clock_control_reg[`AGL_FULL_PD_BIT];
      DYN_PD_TRANSMITTER_OUT <=
        power_and_clock_control_reg[`AGL_DYN_TX_BIT];
      DYN_PD_CONVERTER_OUT <=
        power_and_clock_control_reg[`AGL_DYN_ADC_BIT];
      DYN_PD_AMPLIFIER_OUT <=
        power_and_clock_control_reg[`AGL_DYN_TIA_BIT];
      DYN_PD_CONVERTER_REST_OUT <=
        power_and_clock_control_reg[`AGL_DYN_ADC_REST_BIT];
    end
  end

endmodule // agl_regs

// [sim/agl_regs_monitor.sv]
// Purpose: Concurrent checks on the gain, LED and power register bank
// Assumes: One clock domain, synchronous active-high reset
// Notes: Shadows the write-only pulse select, since reads never show it
`include "agl_defs.vh"

module agl_regs_monitor (
  input wire CLOCK_IN, SYS_RST_IN, REG_WR_EN_IN, REG_RD_EN_IN, ADC_READY_IN,
  input wire [`AGL_ADDR_W-1:0] REG_ADDR_IN,
  input wire [`AGL_DATA_W-1:0] REG_WDATA_IN, REG_RDATA_OUT,
  input wire [`AGL_COUNT_W-1:0] TIMING_COUNT_IN,
  input wire [`AGL_COUNT_W-1:0] PROG_PULSE_START_COUNT_IN,
  input wire [`AGL_COUNT_W-1:0] PROG_PULSE_END_COUNT_IN,
  input wire REG_RVALID_OUT, READY_PIN_OUT, SEPARATE_GAIN_ENABLE_OUT,
  input wire [2:0] FIRST_RES_CODE_OUT, SECOND_RES_CODE_OUT,
  input wire [2:0] FIRST_CAP_CODE_OUT, SECOND_CAP_CODE_OUT,
  input wire [`AGL_OHMS_W-1:0] FIRST_RES_OHMS_OUT, SECOND_RES_OHMS_OUT,
  input wire [`AGL_CAP_W-1:0] FIRST_CAP_TENTH_PF_OUT, SECOND_CAP_TENTH_PF_OUT,
  input wire [`AGL_LED_UA_W-1:0] FIRST_LED_UA_OUT, SECOND_LED_UA_OUT,
  input wire [`AGL_LED_UA_W-1:0] THIRD_LED_UA_OUT,
  input wire DOUBLE_CURRENT_RANGE_OUT, INTERNAL_CLOCK_SELECT_OUT,
  input wire RECEIVER_POWERDOWN_OUT, FULL_POWERDOWN_OUT,
  input wire DYN_PD_TRANSMITTER_OUT, DYN_PD_CONVERTER_OUT,
  input wire DYN_PD_AMPLIFIER_OUT, DYN_PD_CONVERTER_REST_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int OHMS [0:7] = '{500000, 250000, 100000, 50000, 25000, 10000,
    1000000, 2000000};
  localparam int CAPS [0:7] = '{50, 25, 100, 75, 200, 175, 250, 225};
  logic sel_q;
  // LED step doubles with the range bit
  wire [11:0] step_ua = DOUBLE_CURRENT_RANGE_OUT ? 12'h640 : 12'h320;
  wire [23:0] pwr_bits = {3'h0, DYN_PD_TRANSMITTER_OUT, 2'h0,
    DOUBLE_CURRENT_RANGE_OUT, 2'h0, DYN_PD_CONVERTER_OUT, 4'h0,
    INTERNAL_CLOCK_SELECT_OUT, 4'h0, DYN_PD_AMPLIFIER_OUT,
    DYN_PD_CONVERTER_REST_OUT, 1'b0, RECEIVER_POWERDOWN_OUT,
    FULL_POWERDOWN_OUT};

  // Shadow select flop, written by every 21h write like the real one
  always @(posedge CLOCK_IN) begin
    if (SYS_RST_IN)
      sel_q <= 1'b0;
    else if (REG_WR_EN_IN && REG_ADDR_IN == 8'h21)
      sel_q <= REG_WDATA_IN[8];
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // A write lands at its edge, settings show one edge later
  sequence s_wr(a);
    REG_WR_EN_IN && REG_ADDR_IN == a;
  endsequence

  property p_reset_clear;
    disable iff (1'b0) SYS_RST_IN |=> !REG_RVALID_OUT && !READY_PIN_OUT &&
      THIRD_LED_UA_OUT == 0 && !FULL_POWERDOWN_OUT && pwr_bits == 0 &&
      !SEPARATE_GAIN_ENABLE_OUT && FIRST_RES_OHMS_OUT == OHMS[0];
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not cleared by reset");
  property p_rd20;
    REG_RD_EN_IN && REG_ADDR_IN == 8'h20 |=> REG_RVALID_OUT &&
      (REG_RDATA_OUT & 24'hff7fc0) == 24'h0;
  endproperty
  a_rd20: assert property (p_rd20)
    else $error("reserved bits of 20h read nonzero");
  property p_rd21;
    REG_RD_EN_IN && REG_ADDR_IN == 8'h21 |=> REG_RDATA_OUT[23:6] == 18'h0;
  endproperty
  a_rd21: assert property (p_rd21)
    else $error("write-only bits of 21h read nonzero");
  property p_sep;
    s_wr(8'h20) ##0 REG_WDATA_IN[15] |-> ##2 SEPARATE_GAIN_ENABLE_OUT &&
      SECOND_RES_CODE_OUT == $past(REG_WDATA_IN[2:0], 2) &&
      SECOND_CAP_CODE_OUT == $past(REG_WDATA_IN[5:3], 2);
  endproperty
  a_sep: assert property (p_sep)
    else $error("second gain set does not follow 20h");
  property p_first;
    s_wr(8'h21) |-> ##2 FIRST_RES_CODE_OUT == $past(REG_WDATA_IN[2:0], 2) &&
      FIRST_CAP_CODE_OUT == $past(REG_WDATA_IN[5:3], 2);
  endproperty
  a_first: assert property (p_first)
    else $error("first gain set does not follow 21h");
  property p_single;
    !SEPARATE_GAIN_ENABLE_OUT |-> SECOND_RES_CODE_OUT == FIRST_RES_CODE_OUT
      && SECOND_CAP_CODE_OUT == FIRST_CAP_CODE_OUT;
  endproperty
  a_single: assert property (p_single)
    else $error("gain sets differ in single mode");
  property p_decode;
    FIRST_RES_OHMS_OUT == OHMS[FIRST_RES_CODE_OUT] &&
      SECOND_RES_OHMS_OUT == OHMS[SECOND_RES_CODE_OUT] &&
      FIRST_CAP_TENTH_PF_OUT == CAPS[FIRST_CAP_CODE_OUT] &&
      SECOND_CAP_TENTH_PF_OUT == CAPS[SECOND_CAP_CODE_OUT];
  endproperty
  a_decode: assert property (p_decode)
    else $error("gain code decode wrong");
  property p_led;
    s_wr(8'h22) |-> ##2
      FIRST_LED_UA_OUT == $past(REG_WDATA_IN[5:0], 2) * step_ua &&
      SECOND_LED_UA_OUT == $past(REG_WDATA_IN[11:6], 2) * step_ua &&
      THIRD_LED_UA_OUT == $past(REG_WDATA_IN[17:12], 2) * step_ua;
  endproperty
  a_led: assert property (p_led)
    else $error("LED current does not follow 22h");
  property p_pwr;
    s_wr(8'h23) |-> ##2 pwr_bits == ($past(REG_WDATA_IN, 2) & 24'h12421b);
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power and clock bits do not follow 23h");
  property p_ready_direct;
    !sel_q |=> READY_PIN_OUT == $past(ADC_READY_IN);
  endproperty
  a_ready_direct: assert property (p_ready_direct)
    else $error("ready pin does not follow conversion ready");
  property p_pulse_on;
    sel_q && TIMING_COUNT_IN == PROG_PULSE_START_COUNT_IN &&
      TIMING_COUNT_IN != PROG_PULSE_END_COUNT_IN |=> READY_PIN_OUT;
  endproperty
  a_pulse_on: assert property (p_pulse_on)
    else $error("pulse did not start at start count");
  property p_pulse_off;
    sel_q && TIMING_COUNT_IN == PROG_PULSE_END_COUNT_IN |=> !READY_PIN_OUT;
  endproperty
  a_pulse_off: assert property (p_pulse_off)
    else $error("pulse did not end at end count");
endmodule // agl_regs_monitor

// [sim/agl_regs_tb_top.sv]
// Purpose: Self-checking bench for the gain, LED and power register bank
// Assumes: One-cycle strobes, read answer one edge after the strobe
// Notes: Pulse counts are driven straight from the bench
`include "agl_defs.vh"

module agl_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK_IN = 0, SYS_RST_IN = 1, REG_WR_EN_IN = 0, REG_RD_EN_IN = 0;
  logic ADC_READY_IN = 0;
  logic [`AGL_ADDR_W-1:0] REG_ADDR_IN = 8'h00;
  logic [`AGL_DATA_W-1:0] REG_WDATA_IN = 24'h000000, REG_RDATA_OUT;
  logic [`AGL_COUNT_W-1:0] TIMING_COUNT_IN = 16'h0000;
  logic [`AGL_COUNT_W-1:0] PROG_PULSE_START_COUNT_IN = 16'h0002;
  logic [`AGL_COUNT_W-1:0] PROG_PULSE_END_COUNT_IN = 16'h0005;
  logic REG_RVALID_OUT, READY_PIN_OUT, SEPARATE_GAIN_ENABLE_OUT;
  logic [2:0] FIRST_RES_CODE_OUT, SECOND_RES_CODE_OUT;
  logic [2:0] FIRST_CAP_CODE_OUT, SECOND_CAP_CODE_OUT;
  logic [`AGL_OHMS_W-1:0] FIRST_RES_OHMS_OUT, SECOND_RES_OHMS_OUT;
  logic [`AGL_CAP_W-1:0] FIRST_CAP_TENTH_PF_OUT, SECOND_CAP_TENTH_PF_OUT;
  logic [`AGL_LED_UA_W-1:0] FIRST_LED_UA_OUT, SECOND_LED_UA_OUT;
  logic [`AGL_LED_UA_W-1:0] THIRD_LED_UA_OUT;
  logic DOUBLE_CURRENT_RANGE_OUT, INTERNAL_CLOCK_SELECT_OUT;
  logic RECEIVER_POWERDOWN_OUT, FULL_POWERDOWN_OUT, DYN_PD_TRANSMITTER_OUT;
  logic DYN_PD_CONVERTER_OUT, DYN_PD_AMPLIFIER_OUT, DYN_PD_CONVERTER_REST_OUT;
  int errors = 0, checked = 0, i;
  int ohms_t [0:7] = '{500000, 250000, 100000, 50000, 25000, 10000, 1000000,
    2000000};
  int cap_t [0:7] = '{50, 25, 100, 75, 200, 175, 250, 225};
  wire [23:0] pwr = {3'h0, DYN_PD_TRANSMITTER_OUT, 2'h0,
    DOUBLE_CURRENT_RANGE_OUT, 2'h0, DYN_PD_CONVERTER_OUT, 4'h0,
    INTERNAL_CLOCK_SELECT_OUT, 4'h0, DYN_PD_AMPLIFIER_OUT,
    DYN_PD_CONVERTER_REST_OUT, 1'b0, RECEIVER_POWERDOWN_OUT,
    FULL_POWERDOWN_OUT};

  agl_regs dut (.*);

  // 125 MHz clock
  initial begin
    forever #4 CLOCK_IN = ~CLOCK_IN;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] exp, got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h got %h", name, exp, got);
    end
  endtask

  // Write, then wait until the settings have moved
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge CLOCK_IN);
    REG_WR_EN_IN <= 1'b1;
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= d;
    @(posedge CLOCK_IN);
    REG_WR_EN_IN <= 1'b0;
    @(posedge CLOCK_IN);
    #1;
  endtask

  // Read with a bounded wait on the valid flag
  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    int n;
    @(posedge CLOCK_IN);
    REG_RD_EN_IN <= 1'b1;
    REG_ADDR_IN <= a;
    @(posedge CLOCK_IN);
    REG_RD_EN_IN <= 1'b0;
    // Let the answer settle; it is launched by this very edge
    #1;
    for (n = 0; n < 4 && REG_RVALID_OUT !== 1'b1; n++) begin
      @(posedge CLOCK_IN);
      #1;
    end
    chk("read_valid", 24'h1, {23'h0, REG_RVALID_OUT});
    if (REG_RVALID_OUT !== 1'b1) begin
      close_out();
    end else begin
      chk("read_data", exp, REG_RDATA_OUT);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge CLOCK_IN);
    SYS_RST_IN <= 1'b0;
    for (i = 0; i < 4; i++) rd(8'h20 + i[7:0], 24'h0);
    chk("res_ohms", ohms_t[0], FIRST_RES_OHMS_OUT);
    rd(8'h24, 24'h0);
    wr(8'h20, 24'h00803f);
    rd(8'h20, 24'h00803f);
    chk("sep", 24'h1, {23'h0, SEPARATE_GAIN_ENABLE_OUT});
    chk("res2", 24'h7, {21'h0, SECOND_RES_CODE_OUT});
    chk("cap2", 24'h7, {21'h0, SECOND_CAP_CODE_OUT});
    // Every resistor and capacitor code, second set held by 20h
    for (i = 0; i < 8; i++) begin
      wr(8'h21, {18'h0, i[2:0], ~i[2:0]});
      chk("res1", ohms_t[7 - i], FIRST_RES_OHMS_OUT);
      chk("cap1", cap_t[i], FIRST_CAP_TENTH_PF_OUT);
      chk("res2", ohms_t[7], SECOND_RES_OHMS_OUT);
      chk("cap2", cap_t[7], SECOND_CAP_TENTH_PF_OUT);
    end
    wr(8'h20, 24'h000000);
    wr(8'h21, 24'h00012a);
    rd(8'h21, 24'h00002a);
    chk("res2", 24'h2, {21'h0, SECOND_RES_CODE_OUT});
    chk("cap2", 24'h5, {21'h0, SECOND_CAP_CODE_OUT});
    // Pulse replaces conversion ready, which is held high meanwhile
    for (i = 0; i < 8; i++) begin
      @(posedge CLOCK_IN);
      TIMING_COUNT_IN <= i[15:0];
      ADC_READY_IN <= 1'b1;
      #1;
      chk("pulse", {23'h0, i > 2 && i < 6}, {23'h0, READY_PIN_OUT});
    end
    wr(8'h21, 24'h00002a);
    for (i = 0; i < 2; i++) begin
      @(posedge CLOCK_IN);
      ADC_READY_IN <= !i[0];
      @(posedge CLOCK_IN);
      #1;
      chk("ready", {23'h0, !i[0]}, {23'h0, READY_PIN_OUT});
    end
    wr(8'h22, 24'h03f040);
    rd(8'h22, 24'h03f040);
    chk("led1", 24'h0, FIRST_LED_UA_OUT);
    chk("led2", 800, SECOND_LED_UA_OUT);
    chk("led3", 63 * 800, THIRD_LED_UA_OUT);
    wr(8'h23, 24'h12421b);
    rd(8'h23, 24'h12421b);
    chk("pwr", 24'h12421b, pwr);
    chk("led3", 63 * 1600, THIRD_LED_UA_OUT);
    wr(8'h23, 24'h000002);
    chk("pwr", 24'h000002, pwr);
    chk("led2", 800, SECOND_LED_UA_OUT);
    // Second reset in mid-run
    @(posedge CLOCK_IN);
    SYS_RST_IN <= 1'b1;
    repeat (2) @(posedge CLOCK_IN);
    SYS_RST_IN <= 1'b0;
    for (i = 0; i < 4; i++) rd(8'h20 + i[7:0], 24'h0);
    chk("led3", 24'h0, THIRD_LED_UA_OUT);
    close_out();
  end
endmodule // agl_regs_tb_top

bind agl_regs agl_regs_monitor u_mon (.*);
